// *** hdl/rfp_pkg.sv ***
// Constants for the regulator fault supervision block.
// Assumes a 10 MHz system clock; analog comparisons arrive as synchronous digital levels.
package rfp_pkg;
  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned OC_SAMPLE_NS   = 15_000;
  localparam int unsigned SHORT_NS       = 2_000;
  localparam int unsigned PERSIST_NS     = 1_000_000;
  localparam int unsigned NS_PER_S       = 1_000_000_000;
  localparam int unsigned OC_SAMPLE_CYC  = OC_SAMPLE_NS / (NS_PER_S / CLK_HZ);
  localparam int unsigned SHORT_CYC      = SHORT_NS / (NS_PER_S / CLK_HZ);
  localparam int unsigned PERSIST_CYC    = PERSIST_NS / (NS_PER_S / CLK_HZ);
  // ==========================================================================
  // Counter limits
  localparam int unsigned OC_TRIP_COUNT  = 8;
  localparam int unsigned OC_CNT_W       = 4;
  localparam int unsigned TMR_W          = 14;
  // ==========================================================================
  // Supervisor states
  typedef enum logic [3:0] {
    RFP_OFF     = 4'h1,
    RFP_STARTUP = 4'h2,
    RFP_RUN     = 4'h4,
    RFP_FAULT   = 4'h8
  } rfp_state_t;
endpackage

// *** hdl/rfp_persist.sv ***
// Persistence timer: a fault level must hold without break for a set number of cycles.
// Assumes the condition input is synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module rfp_persist
  import rfp_pkg::*;
#(
  parameter int unsigned LIMIT = PERSIST_CYC
) (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic clear,
  input  wire logic cond,
  output logic      expired
);
  logic [TMR_W-1:0] count;
  logic [TMR_W-1:0] next_count;
  logic             next_expired;

  always_comb begin
    next_count   = count;
    next_expired = 1'b0;
    if (clear || !cond) begin
      next_count = '0;
    end else if (count == TMR_W'(LIMIT)) begin
      next_expired = 1'b1;
    end else begin
      next_count = count + TMR_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count   <= '0;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      expired <= next_expired;
    end
  end

  a_persist_cont: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(expired) |-> $past(cond) && $past(count) == TMR_W'(LIMIT))
    else $error("Persistence expired without a full run of the condition.");
endmodule
`default_nettype wire

// *** hdl/rfp_top.sv ***
// Fault supervision, gate interlock and ramp source selection of a buck regulator.
// Assumes all comparator levels are synchronous to clk_sys and already debounced.
//
// What this block does
// - Sample the overcurrent comparator every 15us; count up when over, down when under.
// - Latch an overcurrent fault when the counter reaches eight.
// - Above 2.5x threshold, latch overcurrent within 2us, bypassing the counter.
// - Output 300mV below reference for over 1ms latches undervoltage.
// - Output 195mV above reference for over 1ms latches overvoltage.
// - Voltage checks use the reference whether static or still slewing.
// - Any latched ordinary fault forces power good and both gates low, except the low gate while severe overvoltage is latched.
// - Ordinary faults clear only on enable falling or supply power-on reset.
// - Output above 1.55V raises severe overvoltage at once; high gate, power good low.
// - In severe overvoltage, low gate stays high until output drops below 0.76V.
// - Low gate then toggles at 1.55V and 0.76V until power-on reset only.
// - Severe overvoltage still triggers after another fault is latched.
// - No gate rises until the opposite gate has fallen below about 1V.
// - At startup, the overcurrent counter rearms only after sense drops 25mV below set level; the hard-short path is never disarmed.
// - During startup the one-way startup ramp source drives the reference.
// - After startup the two-way transition source charges or discharges per code.
`timescale 1ns/10ps
`default_nettype none
module rfp_top
  import rfp_pkg::*;
#(
  parameter int unsigned PERSIST_LIMIT = PERSIST_CYC,
  parameter int unsigned OC_TRIP       = OC_TRIP_COUNT
) (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic supply_por_n,
  input  wire logic regulator_enable_pin,
  input  wire logic startup_done,
  input  wire logic pwm_high_req,
  input  wire logic code_higher,
  input  wire logic code_lower,
  input  wire logic oc_over,
  input  wire logic oc_hard_short,
  input  wire logic oc_rearm_25mv,
  input  wire logic uv_below_ref,
  input  wire logic ov_above_ref,
  input  wire logic vout_above_severe,
  input  wire logic vout_below_low,
  input  wire logic high_gate_below_1v,
  input  wire logic low_gate_below_1v,
  output logic      high_side_gate,
  output logic      low_side_gate,
  output logic      power_good_output,
  output logic      overcurrent_fault,
  output logic      overvoltage_fault,
  output logic      undervoltage_fault,
  output logic      severe_ov_fault,
  output logic      startup_ramp_source,
  output logic      transition_ramp_charge,
  output logic      transition_ramp_discharge
);
  // ==========================================================================
  // Fault reset conditions
  logic       en_prev;
  logic       en_fall;
  logic       ordinary_clear;

  function automatic logic any_fault(input logic a, input logic b, input logic c);
    any_fault = a | b | c;
  endfunction

  // Power-on reset also clears the severe latch; enable alone does not.
  assign en_fall        = en_prev && !regulator_enable_pin;
  assign ordinary_clear = en_fall || !supply_por_n;

  // ==========================================================================
  // Overcurrent sampling
  localparam int unsigned TICK_W = $clog2(OC_SAMPLE_CYC + 1);
  logic [TICK_W-1:0]                  tick_cnt;
  logic [TICK_W-1:0]                  next_tick_cnt;
  logic                               tick;
  logic [OC_CNT_W-1:0]                oc_cnt;
  logic [OC_CNT_W-1:0]                next_oc_cnt;
  logic                               oc_armed;
  logic                               next_oc_armed;
  logic                               short_exp;
  logic                               uv_exp;
  logic                               ov_exp;

  assign tick = (tick_cnt == TICK_W'(OC_SAMPLE_CYC - 1));

  always_comb begin
    next_tick_cnt = tick ? '0 : tick_cnt + TICK_W'(1);
    next_oc_cnt   = oc_cnt;
    next_oc_armed = oc_armed;
    if (!oc_armed && oc_rearm_25mv) begin
      next_oc_armed = 1'b1;
    end
    if (ordinary_clear) begin
      next_oc_cnt   = '0;
      next_oc_armed = 1'b0;
    end else if (tick && oc_armed) begin
      if (oc_over) begin
        if (oc_cnt != OC_CNT_W'(OC_TRIP)) begin
          next_oc_cnt = oc_cnt + OC_CNT_W'(1);
        end
      end else if (oc_cnt != '0) begin
        next_oc_cnt = oc_cnt - OC_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= '0;
      oc_cnt   <= '0;
      oc_armed <= 1'b0;
      en_prev  <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      oc_cnt   <= next_oc_cnt;
      oc_armed <= next_oc_armed;
      en_prev  <= regulator_enable_pin;
    end
  end

  // Hard short is filtered for 18 cycles, so the fault latches 20 cycles (the full 2us) after it starts.
  rfp_persist #(.LIMIT(SHORT_CYC - 2)) u_short (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .clear   (ordinary_clear),
    .cond    (oc_hard_short),
    .expired (short_exp)
  );

  // The reference comparisons come in live, so a slewing ramp is checked too.
  rfp_persist #(.LIMIT(PERSIST_LIMIT)) u_uv (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .clear   (ordinary_clear),
    .cond    (uv_below_ref),
    .expired (uv_exp)
  );

  rfp_persist #(.LIMIT(PERSIST_LIMIT)) u_ov (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .clear   (ordinary_clear),
    .cond    (ov_above_ref),
    .expired (ov_exp)
  );

  // ==========================================================================
  // Fault latches
  logic next_ocf;
  logic next_ovf;
  logic next_uvf;
  logic next_sov;
  logic sov_lg;
  logic next_sov_lg;
  logic ord_fault;

  always_comb begin
    next_ocf    = overcurrent_fault;
    next_ovf    = overvoltage_fault;
    next_uvf    = undervoltage_fault;
    next_sov    = severe_ov_fault;
    next_sov_lg = sov_lg;
    if (ordinary_clear) begin
      next_ocf = 1'b0;
      next_ovf = 1'b0;
      next_uvf = 1'b0;
    end
    // A saturated counter is wiped by the same clear, so it must not re-latch the fault.
    if (oc_cnt == OC_CNT_W'(OC_TRIP) && !ordinary_clear) begin
      next_ocf = 1'b1;
    end
    if (short_exp) begin
      next_ocf = 1'b1;
    end
    if (uv_exp) begin
      next_uvf = 1'b1;
    end
    if (ov_exp) begin
      next_ovf = 1'b1;
    end
    if (vout_above_severe) begin
      next_sov    = 1'b1;
      next_sov_lg = 1'b1;
    end else if (vout_below_low) begin
      next_sov_lg = 1'b0;
    end
    if (!supply_por_n) begin
      next_sov    = 1'b0;
      next_sov_lg = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      overcurrent_fault  <= 1'b0;
      overvoltage_fault  <= 1'b0;
      undervoltage_fault <= 1'b0;
      severe_ov_fault    <= 1'b0;
      sov_lg             <= 1'b0;
    end else begin
      overcurrent_fault  <= next_ocf;
      overvoltage_fault  <= next_ovf;
      undervoltage_fault <= next_uvf;
      severe_ov_fault    <= next_sov;
      sov_lg             <= next_sov_lg;
    end
  end

  assign ord_fault = any_fault(overcurrent_fault, overvoltage_fault, undervoltage_fault);

  // ==========================================================================
  // Sequencer and ramp source
  rfp_state_t state;
  rfp_state_t next_state;

  always_comb begin
    case (state)
      RFP_OFF:     next_state = regulator_enable_pin ? RFP_STARTUP : RFP_OFF;
      RFP_STARTUP: next_state = startup_done ? RFP_RUN : RFP_STARTUP;
      RFP_RUN:     next_state = RFP_RUN;
      RFP_FAULT:   next_state = RFP_FAULT;
      default:     next_state = RFP_OFF;
    endcase
    if (state != RFP_OFF && (ord_fault || severe_ov_fault)) begin
      next_state = RFP_FAULT;
    end
    if (!regulator_enable_pin || !supply_por_n) begin
      next_state = RFP_OFF;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= RFP_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs and gate interlock
  logic next_hg;
  logic next_lg;
  logic next_pg;
  logic next_ss;
  logic next_chg;
  logic next_dis;
  logic run_ok;

  assign run_ok = (state == RFP_STARTUP || state == RFP_RUN) && !ord_fault && !severe_ov_fault;

  always_comb begin
    next_ss  = (state == RFP_STARTUP) && run_ok;
    next_chg = (state == RFP_RUN) && run_ok && code_higher;
    next_dis = (state == RFP_RUN) && run_ok && code_lower && !code_higher;
    next_pg  = (state == RFP_RUN) && run_ok;
    next_hg  = 1'b0;
    next_lg  = 1'b0;
    if (severe_ov_fault) begin
      next_lg = sov_lg && high_gate_below_1v && !high_side_gate;
    end else if (run_ok) begin
      next_hg = pwm_high_req && low_gate_below_1v && !low_side_gate;
      next_lg = !pwm_high_req && high_gate_below_1v && !high_side_gate;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      high_side_gate            <= 1'b0;
      low_side_gate             <= 1'b0;
      power_good_output         <= 1'b0;
      startup_ramp_source       <= 1'b0;
      transition_ramp_charge    <= 1'b0;
      transition_ramp_discharge <= 1'b0;
    end else begin
      high_side_gate            <= next_hg;
      low_side_gate             <= next_lg;
      power_good_output         <= next_pg;
      startup_ramp_source       <= next_ss;
      transition_ramp_charge    <= next_chg;
      transition_ramp_discharge <= next_dis;
    end
  end

  // ==========================================================================
  // Checks
  a_oc_count_trip: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (oc_cnt == OC_CNT_W'(OC_TRIP) && !ordinary_clear) |=> overcurrent_fault)
    else $error("Counter at trip without overcurrent fault.");
  a_oc_step_one: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !tick && !ordinary_clear |=> $stable(oc_cnt))
    else $error("Overcurrent counter moved between samples.");
  a_oc_sat_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    oc_cnt == '0 && !oc_over |=> oc_cnt == '0)
    else $error("Overcurrent counter went below zero.");
  a_short_latch: assert property (@(posedge clk_sys) disable iff (!arst_n)
    oc_hard_short [*8] ##1 oc_hard_short [*8] ##1 oc_hard_short [*4]
    |=> overcurrent_fault)
    else $error("Hard short not latched within 2us.");
  a_fault_gates: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ord_fault && !severe_ov_fault |=> !high_side_gate && !low_side_gate && !power_good_output)
    else $error("Gate or power good high during a latched fault.");
  a_severe_now: assert property (@(posedge clk_sys) disable iff (!arst_n)
    vout_above_severe && supply_por_n |=> severe_ov_fault ##1 !high_side_gate)
    else $error("Severe overvoltage not raised at once.");
  a_severe_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    severe_ov_fault && supply_por_n && regulator_enable_pin |=> severe_ov_fault)
    else $error("Severe overvoltage cleared without power-on reset.");
  a_severe_lg_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
    severe_ov_fault && vout_below_low && !vout_above_severe |=> ##1 !low_side_gate)
    else $error("Low gate stayed high below the low threshold.");
  a_no_overlap: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(high_side_gate && low_side_gate))
    else $error("Both gates high together.");
  a_fault_keep: assert property (@(posedge clk_sys) disable iff (!arst_n)
    overvoltage_fault && !ordinary_clear |=> overvoltage_fault)
    else $error("Overvoltage fault lost without a reset condition.");
  a_ramp_excl: assert property (@(posedge clk_sys) disable iff (!arst_n)
    startup_ramp_source |-> !transition_ramp_charge && !transition_ramp_discharge)
    else $error("Two ramp sources selected together.");

  c_oc_trip:   cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(overcurrent_fault));
  c_uv_trip:   cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(undervoltage_fault));
  c_sov_cycle: cover property (@(posedge clk_sys) disable iff (!arst_n)
    severe_ov_fault && low_side_gate ##[1:50] !low_side_gate);
  c_to_run:    cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(power_good_output));
endmodule
`default_nettype wire

// *** sim/rfp_stage_model.sv ***
// Power stage model: reports when each gate has fallen below about 1V.
// Assumes gate levels are registered on clk_sys; slow selects a sluggish stage.
`timescale 1ns/10ps
`default_nettype none
module rfp_stage_model (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic slow,
  input  wire logic high_side_gate,
  input  wire logic low_side_gate,
  output logic      high_gate_below_1v,
  output logic      low_gate_below_1v
);
  // ==========================================================================
  // Gate discharge
  // A released gate needs one cycle, or three when slow, to pass below 1V.
  logic [2:0] hi_hist;
  logic [2:0] lo_hist;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hi_hist <= 3'h0;
      lo_hist <= 3'h0;
    end else begin
      hi_hist <= {hi_hist[1:0], high_side_gate};
      lo_hist <= {lo_hist[1:0], low_side_gate};
    end
  end
  assign high_gate_below_1v = !high_side_gate && (slow ? hi_hist == 3'h0 : !hi_hist[0]);
  assign low_gate_below_1v  = !low_side_gate && (slow ? lo_hist == 3'h0 : !lo_hist[0]);
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the regulator fault supervision block.
// Assumes the stage model answers the gate feedback; only the persistence limit is shortened.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import rfp_pkg::*;
  localparam int LIM = 20;
  localparam int TICK = OC_SAMPLE_CYC;
  logic clk_sys = 1'b0, arst_n = 1'b0, supply_por_n = 1'b1, en = 1'b0;
  logic startup_done = 1'b0, pwm_high_req = 1'b0, code_higher = 1'b0;
  logic code_lower = 1'b0, oc_over = 1'b0, oc_hard_short = 1'b0;
  logic oc_rearm_25mv = 1'b0, slow = 1'b0, vout_above_severe = 1'b0;
  logic vout_below_low = 1'b0;
  logic [1:0] vwin = 2'h0;
  logic hbv, lbv, prev_lbv, prev_hg;
  wire logic [9:0] outs;
  logic [31:0] seed = 32'h1E7BB43F;
  int miscompares = 0, checks_done = 0, hg_rises = 0, n;
  always #50 clk_sys = ~clk_sys;
  rfp_top #(.PERSIST_LIMIT(LIM)) i_rfp_top (
    .clk_sys(clk_sys), .arst_n(arst_n), .supply_por_n(supply_por_n),
    .regulator_enable_pin(en), .startup_done(startup_done),
    .pwm_high_req(pwm_high_req), .code_higher(code_higher), .code_lower(code_lower),
    .oc_over(oc_over), .oc_hard_short(oc_hard_short), .oc_rearm_25mv(oc_rearm_25mv),
    .uv_below_ref(vwin[0]), .ov_above_ref(vwin[1]),
    .vout_above_severe(vout_above_severe), .vout_below_low(vout_below_low),
    .high_gate_below_1v(hbv), .low_gate_below_1v(lbv),
    .high_side_gate(outs[0]), .low_side_gate(outs[1]), .power_good_output(outs[2]),
    .overcurrent_fault(outs[3]), .overvoltage_fault(outs[4]),
    .undervoltage_fault(outs[5]), .severe_ov_fault(outs[6]),
    .startup_ramp_source(outs[7]), .transition_ramp_charge(outs[8]),
    .transition_ramp_discharge(outs[9]));
  rfp_stage_model i_rfp_stage_model (
    .clk_sys(clk_sys), .arst_n(arst_n), .slow(slow), .high_side_gate(outs[0]),
    .low_side_gate(outs[1]), .high_gate_below_1v(hbv), .low_gate_below_1v(lbv));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs32(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  // Sampling on the falling edge keeps clear of the design's own updates.
  task automatic wait_bit(input int idx, input logic val, input int lim, output int c);
    c = 0;
    do begin
      @(negedge clk_sys);
      c++;
    end while (outs[idx] !== val && c < lim);
    chk($sformatf("out%0d", idx), outs[idx], val);
    if (outs[idx] !== val) tally_and_finish();
  endtask
  task automatic cycle_en();
    tick(1);
    en <= 1'b0;
    tick(4);
    en <= 1'b1;
  endtask
  // ==========================================================================
  // Random modulator demand and stage speed, plus a shoot-through watch
  always @(posedge clk_sys) begin
    seed = xs32(seed);
    pwm_high_req <= seed[0];
    slow <= seed[5];
  end
  always @(negedge clk_sys) begin
    chk("no_overlap", outs[0] & outs[1], 1'b0);
    if (outs[0] === 1'b1 && prev_hg === 1'b0) begin
      hg_rises++;
      chk("hg_after_low_off", prev_lbv, 1'b1);
    end
    prev_hg = outs[0];
    prev_lbv = lbv;
  end
  // ==========================================================================
  // Main sequence
  initial begin
    tick(12);
    arst_n <= 1'b1;
    tick(1);
    chk("reset_outs", outs == 10'h000, 1'b1);
    en <= 1'b1;
    wait_bit(7, 1'b1, 10, n);
    tick(1);
    code_higher <= 1'b1;
    startup_done <= 1'b1;
    wait_bit(8, 1'b1, 10, n);
    wait_bit(2, 1'b1, 10, n);
    chk("ss_off", outs[7], 1'b0);
    tick(1);
    code_higher <= 1'b0;
    code_lower <= 1'b1;
    wait_bit(9, 1'b1, 10, n);
    tick(1);
    code_lower <= 1'b0;
    oc_over <= 1'b1;
    tick(10 * TICK);
    chk("oc_unarmed", outs[3], 1'b0);
    oc_over <= 1'b0;
    oc_rearm_25mv <= 1'b1;
    tick(1);
    oc_rearm_25mv <= 1'b0;
    oc_over <= 1'b1;
    tick(6 * TICK);
    oc_over <= 1'b0;
    chk("oc_six", outs[3], 1'b0);
    tick(3 * TICK);
    oc_over <= 1'b1;
    wait_bit(3, 1'b1, 8 * TICK, n);
    chk("oc_downcount", n >= 3 * TICK, 1'b1);
    wait_bit(2, 1'b0, 4, n);
    tick(2);
    chk("gates_low", outs[1:0] == 2'h0, 1'b1);
    oc_over <= 1'b0;
    cycle_en();
    wait_bit(3, 1'b0, 6, n);
    oc_rearm_25mv <= 1'b1;
    tick(1);
    oc_rearm_25mv <= 1'b0;
    oc_hard_short <= 1'b1;
    wait_bit(3, 1'b1, SHORT_CYC + 4, n);
    oc_hard_short <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      cycle_en();
      startup_done <= k[0];
      tick(6);
      repeat (2) begin
        vwin[k] <= 1'b1;
        tick(LIM - 5);
        vwin[k] <= 1'b0;
        tick(1);
      end
      chk("persist_restart", outs[5 - k], 1'b0);
      vwin[k] <= 1'b1;
      wait_bit(5 - k, 1'b1, LIM + 6, n);
      chk("persist_len", n >= LIM, 1'b1);
      vwin[k] <= 1'b0;
    end
    vout_above_severe <= 1'b1;
    wait_bit(6, 1'b1, 3, n);
    wait_bit(1, 1'b1, 8, n);
    chk("sv_hg_pg", outs[2:0] == 3'h2, 1'b1);
    vout_above_severe <= 1'b0;
    vout_below_low <= 1'b1;
    wait_bit(1, 1'b0, 4, n);
    vout_below_low <= 1'b0;
    vout_above_severe <= 1'b1;
    wait_bit(1, 1'b1, 8, n);
    vout_above_severe <= 1'b0;
    cycle_en();
    tick(4);
    chk("sv_keeps", outs[6], 1'b1);
    supply_por_n <= 1'b0;
    wait_bit(6, 1'b0, 4, n);
    chk("ov_cleared", outs[4], 1'b0);
    chk("gates_seen", hg_rises > 0, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
